// File: gpio4_params.svh
// constants for the four-bit gpio port: offsets, field positions, reset values
`ifndef GPIO4_PARAMS_SVH
`define GPIO4_PARAMS_SVH
`define GPIO4_OFF_DATA 12'h000
`define GPIO4_OFF_LAT 12'h004
`define GPIO4_OFF_DIR 12'h008
`define GPIO4_OFF_ANSEL 12'h00C
`define GPIO4_OFF_ODRAIN 12'h010
`define GPIO4_OFF_SLEW 12'h014
`define GPIO4_OFF_THRESH 12'h018
`define GPIO4_OFF_PSEL 12'h01C
`define GPIO4_PIN_LSB 4
`define GPIO4_PIN_MSB 7
`define GPIO4_NPINS 4
`define GPIO4_NREGS 8
`define GPIO4_RST_DIR 4'hF
`define GPIO4_RST_ANSEL 4'hF
`define GPIO4_RST_ZERO 4'h0
`define GPIO4_HTRANS_NONSEQ 2'h2
`define GPIO4_HSIZE_WORD 3'h2
`endif

// File: gpio4_pkg.sv
// types shared by the four-bit gpio port
package gpio4_pkg;
    typedef logic [3:0] gpio4_nib_t;
    typedef struct packed {
        logic [3:0] out_val;
        logic [3:0] out_en;
        logic [3:0] slew_lim;
        logic [3:0] ana_en;
    } gpio4_pad_s;
    typedef enum logic [0:0] {
        GPIO4_IDLE = 1'b0,
        GPIO4_DATA = 1'b1
    } gpio4_phase_e;
endpackage : gpio4_pkg

// File: gpio4_regfile.sv
// small register store for the four-bit configuration words
`timescale 1ns/1ps
`default_nettype none
`include "gpio4_params.svh"
module gpio4_regfile
    import gpio4_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire logic [3:0] wdata,
    input wire logic [2:0] raddr,
    output logic [3:0] rdata_q
);
    logic [3:0] mem_q [0:7];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < 8; i++)
            begin
                // direction and analog words leave reset set, as their registers do
                mem_q[i] <= (i == (`GPIO4_OFF_DIR >> 2)) ? `GPIO4_RST_DIR
                          : (i == (`GPIO4_OFF_ANSEL >> 2)) ? `GPIO4_RST_ANSEL : 4'h0;
            end
        end
        else if (we)
        begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q <= 4'h0;
        end
        else
        begin
            rdata_q <= mem_q[raddr];
        end
    end
endmodule : gpio4_regfile
`default_nettype wire

// File: gpio4_port.sv
// four-bit bidirectional gpio port with ahb-lite register access
// Functional notes
// - four pins, each input or output
// - direction one tristates pin as input
// - direction zero drives pin from latch
// - data read gives pins, write hits latch
// - port writes load write data straight into latch
// - direction still controls driver in analog
// - analog select makes digital reads zero
// - per-pin open-drain: sink only when set
// - per-pin slew limit select
// - threshold select governs digital read
// - analog select leaves digital output alone
// - reset sets every analog select bit
// - output source is latch where periph_sel is zero
// - analog functions connect only when selected
// - pins at bits 7..4, rest zero
// - direction bits reset to one
`timescale 1ns/1ps
`default_nettype none
`include "gpio4_params.svh"
module gpio4_port
    import gpio4_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] pin_in_ttl,
    input wire logic [3:0] pin_in_st,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    output logic [3:0] pin_slew_lim,
    output logic [3:0] pin_ana_en,
    output logic [3:0] pin_dig_in,
    input wire logic [3:0] periph_out,
    input wire logic [3:0] periph_sel
);
    logic [3:0] output_latch_q;
    logic [3:0] direction_bits_q;
    logic [3:0] analog_select_q;
    logic [3:0] open_drain_select_q;
    logic [3:0] slew_limit_select_q;
    logic [3:0] input_threshold_select_q;
    logic [3:0] output_latch_d;
    logic [3:0] direction_bits_d;
    logic [3:0] analog_select_d;
    logic [3:0] open_drain_select_d;
    logic [3:0] slew_limit_select_d;
    logic [3:0] input_threshold_select_d;
    logic rf_we;
    logic [3:0] pin_sample_q;
    gpio4_phase_e phase_q;
    logic [11:0] addr_q;
    logic wr_q;
    logic [31:0] hrdata_q;
    gpio4_pad_s pad_q;
    gpio4_pad_s pad_d;
    logic [3:0] pin_dig_in_q;
    logic [3:0] thresh_level;
    logic [3:0] dig_read;
    logic [3:0] wdat;
    logic [3:0] src_val;
    logic addr_take;
    logic wr_data;
    logic [3:0] rf_rdata;

    function automatic logic [31:0] place_nib(input logic [3:0] n);
        place_nib = {24'h000000, n, 4'h0};
    endfunction : place_nib

    function automatic logic [3:0] hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off) ? 4'hF : 4'h0;
    endfunction : hit

    // bits that a landing write replaces in the register at off
    function automatic logic [3:0] wr_mask(input logic en, input logic [11:0] a,
        input logic [11:0] off);
        wr_mask = en ? hit(a, off) : 4'h0;
    endfunction : wr_mask

    function automatic logic [3:0] merge(input logic [3:0] cur, input logic [3:0] nv,
        input logic [3:0] m);
        merge = (nv & m) | (cur & ~m);
    endfunction : merge

    // threshold select picks which comparator feeds the digital path
    assign thresh_level = (input_threshold_select_q & pin_in_st)
                        | (~input_threshold_select_q & pin_in_ttl);
    assign dig_read = pin_sample_q & ~analog_select_q;
    assign wdat = hwdata[`GPIO4_PIN_MSB:`GPIO4_PIN_LSB];
    assign addr_take = hsel && hready && htrans == `GPIO4_HTRANS_NONSEQ;
    assign wr_data = (phase_q == GPIO4_DATA) && wr_q;

    // next values feed the registers and the read mux alike, so a read whose address
    // phase overlaps a write's data phase already returns the new word
    assign output_latch_d = (wr_data && (addr_q == `GPIO4_OFF_DATA
                                         || addr_q == `GPIO4_OFF_LAT)) ? wdat
                          : output_latch_q;
    assign direction_bits_d = merge(direction_bits_q, wdat,
                                    wr_mask(wr_data, addr_q, `GPIO4_OFF_DIR));
    assign analog_select_d = merge(analog_select_q, wdat,
                                   wr_mask(wr_data, addr_q, `GPIO4_OFF_ANSEL));
    assign open_drain_select_d = merge(open_drain_select_q, wdat,
                                       wr_mask(wr_data, addr_q, `GPIO4_OFF_ODRAIN));
    assign slew_limit_select_d = merge(slew_limit_select_q, wdat,
                                       wr_mask(wr_data, addr_q, `GPIO4_OFF_SLEW));
    assign input_threshold_select_d = merge(input_threshold_select_q, wdat,
                                            wr_mask(wr_data, addr_q, `GPIO4_OFF_THRESH));
    // the shadow store keeps every aligned word written inside the map
    assign rf_we = wr_data && addr_q[11:5] == 7'h00 && addr_q[1:0] == 2'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_sample_q <= `GPIO4_RST_ZERO;
        end
        else
        begin
            pin_sample_q <= thresh_level;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q <= GPIO4_IDLE;
            addr_q <= 12'h000;
            wr_q <= 1'b0;
        end
        else
        begin
            case (phase_q)
                GPIO4_IDLE:
                begin
                    if (addr_take)
                    begin
                        phase_q <= GPIO4_DATA;
                        addr_q <= haddr;
                        wr_q <= hwrite;
                    end
                end
                GPIO4_DATA:
                begin
                    phase_q <= addr_take ? GPIO4_DATA : GPIO4_IDLE;
                    if (addr_take)
                    begin
                        addr_q <= haddr;
                        wr_q <= hwrite;
                    end
                end
                default:
                begin
                    phase_q <= GPIO4_IDLE;
                end
            endcase
        end
    end

    // data and latch offsets share the latch; non-written bits keep latch value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            output_latch_q <= `GPIO4_RST_ZERO;
        end
        else
        begin
            output_latch_q <= output_latch_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            direction_bits_q <= `GPIO4_RST_DIR;
            analog_select_q <= `GPIO4_RST_ANSEL;
            open_drain_select_q <= `GPIO4_RST_ZERO;
            slew_limit_select_q <= `GPIO4_RST_ZERO;
            input_threshold_select_q <= `GPIO4_RST_ZERO;
        end
        else
        begin
            direction_bits_q <= direction_bits_d;
            analog_select_q <= analog_select_d;
            open_drain_select_q <= open_drain_select_d;
            slew_limit_select_q <= slew_limit_select_d;
            input_threshold_select_q <= input_threshold_select_d;
        end
    end

    // shadow copy of written words, cross-checked against the readback below
    gpio4_regfile u_rf (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(rf_we),
        .waddr(addr_q[4:2]),
        .wdata(wdat),
        .raddr(haddr[4:2]),
        .rdata_q(rf_rdata)
    );

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= 32'h00000000;
        end
        else if (addr_take && !hwrite)
        begin
            case (haddr)
                `GPIO4_OFF_DATA: hrdata_q <= place_nib(dig_read);
                `GPIO4_OFF_LAT: hrdata_q <= place_nib(output_latch_d);
                `GPIO4_OFF_DIR: hrdata_q <= place_nib(direction_bits_d);
                `GPIO4_OFF_ANSEL: hrdata_q <= place_nib(analog_select_d);
                `GPIO4_OFF_ODRAIN: hrdata_q <= place_nib(open_drain_select_d);
                `GPIO4_OFF_SLEW: hrdata_q <= place_nib(slew_limit_select_d);
                `GPIO4_OFF_THRESH: hrdata_q <= place_nib(input_threshold_select_d);
                `GPIO4_OFF_PSEL: hrdata_q <= place_nib(periph_sel);
                default: hrdata_q <= 32'h00000000;
            endcase
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // pad drive: direction owns the driver regardless of analog mode
    always_comb
    begin
        src_val = (periph_sel & periph_out) | (~periph_sel & output_latch_q);
        pad_d.out_val = src_val & ~open_drain_select_q;
        pad_d.out_en = ~direction_bits_q
                     & (~open_drain_select_q | ~src_val);
        pad_d.slew_lim = slew_limit_select_q;
        pad_d.ana_en = analog_select_q;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pad_q <= '{out_val: 4'h0, out_en: 4'h0, slew_lim: 4'h0, ana_en: `GPIO4_RST_ANSEL};
            pin_dig_in_q <= `GPIO4_RST_ZERO;
        end
        else
        begin
            pad_q <= pad_d;
            pin_dig_in_q <= dig_read;
        end
    end

    assign pin_out = pad_q.out_val;
    assign pin_oe = pad_q.out_en;
    assign pin_slew_lim = pad_q.slew_lim;
    assign pin_ana_en = pad_q.ana_en;
    assign pin_dig_in = pin_dig_in_q;

    property p_dir_reset;
        @(posedge hclk) $rose(hresetn) |-> direction_bits_q == 4'hF && analog_select_q == 4'hF;
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("config not at reset value");

    property p_input_tristate;
        @(posedge hclk) disable iff (!hresetn)
            (&direction_bits_q) ##1 (&direction_bits_q) |-> pin_oe == 4'h0;
    endproperty
    a_input_tristate: assert property (p_input_tristate) else $error("input pin driven");

    property p_output_drive;
        @(posedge hclk) disable iff (!hresetn)
            (direction_bits_q == 4'h0 && open_drain_select_q == 4'h0 && periph_sel == 4'h0)
            |=> pin_oe == 4'hF && pin_out == $past(output_latch_q);
    endproperty
    a_output_drive: assert property (p_output_drive) else $error("output not latch");

    property p_write_latch;
        @(posedge hclk) disable iff (!hresetn)
            wr_data && addr_q == `GPIO4_OFF_DATA |=> output_latch_q == $past(hwdata[7:4]);
    endproperty
    a_write_latch: assert property (p_write_latch) else $error("data write missed latch");

    property p_analog_zero;
        @(posedge hclk) disable iff (!hresetn)
            (&analog_select_q) |=> pin_dig_in == 4'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_od_high_release;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |=> (pin_out & $past(open_drain_select_q)) == 4'h0
                     && (pin_oe & $past(open_drain_select_q & output_latch_q
                                        & ~periph_sel)) == 4'h0;
    endproperty
    a_od_high_release: assert property (p_od_high_release) else $error("open drain sourced");

    property p_slew;
        @(posedge hclk) disable iff (!hresetn) 1'b1 |=> pin_slew_lim == $past(slew_limit_select_q);
    endproperty
    a_slew: assert property (p_slew) else $error("slew not followed");

    property p_read_zero_low;
        @(posedge hclk) disable iff (!hresetn)
            addr_take && !hwrite |=> hrdata[3:0] == 4'h0 && hrdata[31:8] == 24'h000000;
    endproperty
    a_read_zero_low: assert property (p_read_zero_low) else $error("unused bits nonzero");

    property p_ana_en;
        @(posedge hclk) disable iff (!hresetn) 1'b1 |=> pin_ana_en == $past(analog_select_q);
    endproperty
    a_ana_en: assert property (p_ana_en) else $error("analog enable wrong");

    // a read that overlaps a write data phase is left out: the shadow answers late there
    property p_shadow_read;
        @(posedge hclk) disable iff (!hresetn)
            phase_q == GPIO4_DATA && !wr_q && !$past(wr_data)
            && addr_q inside {`GPIO4_OFF_DIR, `GPIO4_OFF_ANSEL, `GPIO4_OFF_ODRAIN,
                              `GPIO4_OFF_SLEW, `GPIO4_OFF_THRESH}
            |-> hrdata[7:4] == rf_rdata;
    endproperty
    a_shadow_read: assert property (p_shadow_read) else $error("shadow mismatch");

    property p_dir_owns;
        @(posedge hclk) disable iff (!hresetn)
            1'b1 |=> (pin_oe & $past(direction_bits_q)) == 4'h0;
    endproperty
    a_dir_owns: assert property (p_dir_owns) else $error("input pin driven");

    property p_psel_source;
        @(posedge hclk) disable iff (!hresetn)
            periph_sel == 4'hF && open_drain_select_q == 4'h0 |=> pin_out == $past(periph_out);
    endproperty
    a_psel_source: assert property (p_psel_source) else $error("source not followed");

    c_write: cover property (@(posedge hclk) wr_data);
    c_periph: cover property (@(posedge hclk) periph_sel != 4'h0 && pin_oe != 4'h0);
    c_analog_drive: cover property (@(posedge hclk) analog_select_q != 4'h0 && pin_oe != 4'h0);
    c_read: cover property (@(posedge hclk) addr_take && !hwrite);
    c_drive: cover property (@(posedge hclk) pin_oe != 4'h0);
endmodule : gpio4_port
`default_nettype wire

// File: gpio4_pad_model.sv
// board model for the four-bit gpio port: pads with pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none
module gpio4_pad_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_val,
    input wire logic ext_en,
    input wire logic ext_mid,
    output logic [3:0] pin_in_ttl,
    output logic [3:0] pin_in_st
);
    // ext_mid puts undriven pads between thresholds: ttl sees high, schmitt sees low
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (pin_oe[i])
            begin
                pin_in_ttl[i] = pin_out[i];
                pin_in_st[i] = pin_out[i];
            end
            else if (ext_mid)
            begin
                pin_in_ttl[i] = 1'b1;
                pin_in_st[i] = 1'b0;
            end
            else if (ext_en)
            begin
                pin_in_ttl[i] = ext_val[i];
                pin_in_st[i] = ext_val[i];
            end
            else
            begin
                // board pull-up, so a released open-drain pad reads high
                pin_in_ttl[i] = 1'b1;
                pin_in_st[i] = 1'b1;
            end
        end
    end
endmodule : gpio4_pad_model
`default_nettype wire

// File: four_bit_gpio_port_tb_top.sv
// self-checking testbench for the four-bit gpio port
`timescale 1ns/1ps
`default_nettype none
`include "gpio4_params.svh"
module four_bit_gpio_port_tb_top
    import gpio4_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = `GPIO4_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp;
    logic [3:0] pin_in_ttl, pin_in_st, pin_out, pin_oe, pin_slew_lim, pin_ana_en, pin_dig_in;
    logic [3:0] periph_out = 4'h0;
    logic [3:0] periph_sel = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic ext_en = 1'b0;
    logic ext_mid = 1'b0;
    int n_errors = 0;
    int checked = 0;

    always #5 hclk = ~hclk;

    gpio4_port uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in_ttl(pin_in_ttl), .pin_in_st(pin_in_st), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_slew_lim(pin_slew_lim), .pin_ana_en(pin_ana_en),
        .pin_dig_in(pin_dig_in), .periph_out(periph_out), .periph_sel(periph_sel));

    gpio4_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .ext_mid(ext_mid), .pin_in_ttl(pin_in_ttl), .pin_in_st(pin_in_st));

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
        chk({28'h0, got}, {28'h0, exp});
    endtask : chk_pin

    // one single transfer; the address phase is held until hready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= `GPIO4_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wreg

    task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask : chk_reg

    // pin registers follow one edge after the write, input sampling one more
    task automatic settle;
        repeat (3) @(posedge hclk);
    endtask : settle

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        chk_reg(`GPIO4_OFF_DIR, 32'h000000F0);
        chk_reg(`GPIO4_OFF_ANSEL, 32'h000000F0);
        chk_reg(`GPIO4_OFF_ODRAIN, 32'h0);
        chk_reg(`GPIO4_OFF_SLEW, 32'h0);
        chk_pin(pin_oe, 4'h0);
        chk_pin(pin_ana_en, 4'hF);
        ext_en <= 1'b1;
        ext_val <= 4'h5;
        settle;
        chk_reg(`GPIO4_OFF_DATA, 32'h0);
        chk_pin(pin_dig_in, 4'h0);
        wreg(12'h020, 32'hFFFFFFFF);
        chk_reg(12'h020, 32'h0);
        wreg(`GPIO4_OFF_ANSEL, 32'h0);
        settle;
        chk_reg(`GPIO4_OFF_DATA, 32'h00000050);
        chk_pin(pin_dig_in, 4'h5);
        chk_pin(pin_ana_en, 4'h0);
        ext_mid <= 1'b1;
        wreg(`GPIO4_OFF_THRESH, 32'h000000F0);
        settle;
        chk_reg(`GPIO4_OFF_DATA, 32'h0);
        wreg(`GPIO4_OFF_THRESH, 32'h0);
        settle;
        chk_reg(`GPIO4_OFF_DATA, 32'h000000F0);
        ext_mid <= 1'b0;
        wreg(`GPIO4_OFF_DATA, 32'hFFFFFFA5);
        chk_reg(`GPIO4_OFF_LAT, 32'h000000A0);
        settle;
        chk_reg(`GPIO4_OFF_DATA, 32'h00000050);
        wreg(`GPIO4_OFF_DIR, 32'h00000050);
        settle;
        chk_pin(pin_oe, 4'hA);
        chk_pin(pin_out & pin_oe, 4'hA);
        chk_reg(`GPIO4_OFF_DATA, 32'h000000F0);
        wreg(`GPIO4_OFF_DIR, 32'h0);
        settle;
        chk_pin(pin_oe, 4'hF);
        chk_pin(pin_out, 4'hA);
        wreg(`GPIO4_OFF_ANSEL, 32'h000000F0);
        settle;
        chk_pin(pin_oe, 4'hF);
        chk_pin(pin_out, 4'hA);
        chk_reg(`GPIO4_OFF_DATA, 32'h0);
        chk_pin(pin_ana_en, 4'hF);
        wreg(`GPIO4_OFF_ANSEL, 32'h0);
        ext_en <= 1'b0;
        wreg(`GPIO4_OFF_ODRAIN, 32'h000000F0);
        settle;
        chk_pin(pin_oe, 4'h5);
        chk_pin(pin_out & pin_oe, 4'h0);
        chk_reg(`GPIO4_OFF_DATA, 32'h000000A0);
        wreg(`GPIO4_OFF_ODRAIN, 32'h0);
        wreg(`GPIO4_OFF_SLEW, 32'h00000030);
        settle;
        chk_pin(pin_slew_lim, 4'h3);
        periph_out <= 4'h6;
        periph_sel <= 4'hF;
        settle;
        chk_pin(pin_out, 4'h6);
        chk_reg(`GPIO4_OFF_PSEL, 32'h000000F0);
        periph_sel <= 4'h0;
        settle;
        chk_pin(pin_out, 4'hA);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk_reg(`GPIO4_OFF_DIR, 32'h000000F0);
        chk_reg(`GPIO4_OFF_ANSEL, 32'h000000F0);
        wrap_up;
    end

    // the sequence needs about 140 cycles; this leaves ample margin
    initial
    begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        wrap_up;
    end
endmodule : four_bit_gpio_port_tb_top
`default_nettype wire
